/* File: bench/ptc_pin_model.sv */
// Partner model: drives the external clock and capture pins and loads the output pin
module ptc_pin_model (
	input  wire logic clock_i,
	input  wire logic timer_out_i,
	output logic      external_clock_pin_o,
	output logic      capture_input_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int high_n = 0;
	initial begin
		external_clock_pin_o = 1'b0;
		capture_input_pin_o  = 1'b0;
	end
	// The load counts the cycles in which the output pin is high
	always @(negedge clock_i) begin
		if (timer_out_i === 1'b1) high_n++;
	end
	// Pins idle low; each level is held for hold cycles so both edges reach the sampler
	task automatic pulse(input logic sel, input int hold);
		@(posedge clock_i);
		if (sel) external_clock_pin_o <= 1'b1;
		else capture_input_pin_o <= 1'b1;
		repeat (hold) @(posedge clock_i);
		if (sel) external_clock_pin_o <= 1'b0;
		else capture_input_pin_o <= 1'b0;
		repeat (hold) @(posedge clock_i);
	endtask
endmodule // ptc_pin_model

/* File: bench/ptc_timer_test.sv */
// Testbench: register, PWM, single pulse and capture checks for the timer
module ptc_timer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ptc_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic [1:0] rs;} ptc_reg_row_s;
	typedef struct {logic [31:0] ctrl; logic [31:0] compare_a_value; logic [31:0] period_compare_value; int win; int hi;} ptc_pwm_row_s;
	logic        clock_i, rstn_i, ext_pin, cap_pin, tout, tirq;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, r1;
	logic [1:0]  bresp, rresp, rs;
	int          n_mismatch = 0, check_count = 0, irq_n = 0, cyc_n = 0;
	int          exp_cap[4] = '{1, 1, 2, 0};
	ptc_reg_row_s regs[5] = '{'{OFF_CTRL, 32'h0000_0E00, 32'h0000_0E00, RESP_OK},
		'{OFF_COMPARE_A_VALUE, 32'h0000_FFFF, 32'h0000_03FF, RESP_OK}, '{OFF_PERIOD_COMPARE_VALUE, 32'h0000_0155, 32'h0000_0155, RESP_OK},
		'{OFF_COUNT, 32'h0000_0055, RST_REG, RESP_OK}, '{8'h14, 32'h0000_0001, RST_REG, RESP_ERR}};
	ptc_pwm_row_s pwm[11] = '{'{32'h95, 32'h1, 32'h4, 16, 4}, '{32'hB5, 32'h1, 32'h4, 16, 4},
		'{32'h95, 32'h4, 32'h4, 16, 16}, '{32'h95, 32'h7, 32'h4, 16, 16}, '{32'h195, 32'h1, 32'h4, 16, 12},
		'{32'h15, 32'h1, 32'h4, 16, 12}, '{32'h85, 32'h1, 32'h4, 16, 0}, '{32'h8D, 32'h1, 32'h4, 16, 16},
		'{32'h295, 32'h1, 32'h4, 16, 4}, '{32'h95, 32'h200, 32'h0, 2048, 1024}, '{32'h95, 32'h3, 32'h3FF, 1023, 3}};

	ptc_timer u_ptc_timer (
		.clock_i(clock_i), .rstn_i(rstn_i), .external_clock_pin_i(ext_pin), .capture_input_pin_i(cap_pin),
		.timer_out_o(tout), .timer_irq_o(tirq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ptc_pin_model u_ptc_pin_model (.clock_i(clock_i), .timer_out_i(tout),
		.external_clock_pin_o(ext_pin), .capture_input_pin_o(cap_pin));

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	always @(negedge clock_i) begin
		if (tirq === 1'b1) irq_n++;
	end
	// Stimulus totals a few thousand cycles; the ceiling leaves ample slack
	always @(posedge clock_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// Ready is looked at on the falling edge, where it is settled, and the transfer ends on the next rising one
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		fork
			begin
				@(negedge clock_i);
				while (awready !== 1'b1) @(negedge clock_i);
				@(posedge clock_i);
				awvalid <= 1'b0;
			end
			begin
				@(negedge clock_i);
				while (wready !== 1'b1) @(negedge clock_i);
				@(posedge clock_i);
				wvalid <= 1'b0;
			end
		join
		@(negedge clock_i);
		while (bvalid !== 1'b1) @(negedge clock_i);
		rs = bresp;
		@(posedge clock_i);
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge clock_i);
		while (arready !== 1'b1) @(negedge clock_i);
		@(posedge clock_i);
		arvalid <= 1'b0;
		@(negedge clock_i);
		while (rvalid !== 1'b1) @(negedge clock_i);
		rd = rdata;
		rs = rresp;
		@(posedge clock_i);
		rready <= 1'b0;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		rstn_i = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		repeat (5) @(posedge clock_i);
		rstn_i <= 1'b1;
		foreach (regs[i]) begin
			rdr(regs[i].a);
			chk(rd, RST_REG);
			wr(regs[i].a, regs[i].d);
			chk(rs, regs[i].rs);
			rdr(regs[i].a);
			chk(rd, regs[i].rd);
			chk(rs, regs[i].rs);
		end
		foreach (pwm[i]) begin
			wr(OFF_CTRL, RST_REG);
			wr(OFF_PERIOD_COMPARE_VALUE, pwm[i].period_compare_value);
			wr(OFF_COMPARE_A_VALUE, pwm[i].compare_a_value);
			wr(OFF_CTRL, pwm[i].ctrl);
			cyc(8);
			u_ptc_pin_model.high_n = 0;
			irq_n = 0;
			cyc(pwm[i].win);
			chk(u_ptc_pin_model.high_n, pwm[i].hi);
			chk(irq_n > 0, 32'h1);
		end
		// Single pulse with a period value that would cut the pulse short if it were honoured
		wr(OFF_CTRL, RST_REG);
		wr(OFF_PERIOD_COMPARE_VALUE, 32'h3);
		wr(OFF_COMPARE_A_VALUE, 32'hA);
		wr(OFF_CTRL, 32'hBC);
		u_ptc_pin_model.high_n = 0;
		irq_n = 0;
		wr(OFF_CTRL, 32'hBD);
		cyc(40);
		chk(u_ptc_pin_model.high_n inside {[10:13]}, 32'h1);
		chk(irq_n, 32'h1);
		rdr(OFF_CTRL);
		chk(rd, 32'hBC);
		rdr(OFF_COUNT);
		r1 = rd;
		cyc(5);
		rdr(OFF_COUNT);
		chk(rd, r1);
		u_ptc_pin_model.high_n = 0;
		u_ptc_pin_model.pulse(1'b1, 3);
		cyc(40);
		chk(u_ptc_pin_model.high_n inside {[10:13]}, 32'h1);
		wr(OFF_COMPARE_A_VALUE, 32'h12C);
		u_ptc_pin_model.high_n = 0;
		wr(OFF_CTRL, 32'hBD);
		cyc(20);
		wr(OFF_CTRL, 32'hBC);
		cyc(10);
		chk(u_ptc_pin_model.high_n inside {[20:32]}, 32'h1);
		chk(tout, 1'b0);
		// Capture: the unselected pin is toggled first and must be ignored
		wr(OFF_PERIOD_COMPARE_VALUE, RST_REG);
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 4; c++) begin
				wr(OFF_CTRL, RST_REG);
				wr(OFF_CTRL, 32'h3 | (c << 3) | (s << 6) | (s * 32'h1A0));
				irq_n = 0;
				u_ptc_pin_model.pulse(s == 0, 3);
				u_ptc_pin_model.pulse(s == 1, 3);
				cyc(3);
				chk(irq_n, exp_cap[c]);
			end
		end
		wr(OFF_CTRL, RST_REG);
		wr(OFF_STATUS, 32'h3);
		irq_n = 0;
		wr(OFF_CTRL, 32'h3);
		cyc(40);
		u_ptc_pin_model.pulse(1'b0, 3);
		rdr(OFF_COMPARE_A_VALUE);
		chk(rd inside {[32'h28:32'h34]}, 32'h1);
		rdr(OFF_COUNT);
		r1 = rd;
		rdr(OFF_COUNT);
		chk(rd != r1, 32'h1);
		cyc(1000);
		chk(irq_n, 32'h2);
		rdr(OFF_STATUS);
		chk(rd, 32'h3);
		wr(OFF_STATUS, 32'h3);
		rdr(OFF_STATUS);
		chk(rd, RST_REG);
		wrap_up();
	end
endmodule // ptc_timer_test

/* File: core/ptc_pkg.sv */
// Package: register map, field layout and modes of the periodic timer with pulse and capture
package ptc_pkg;
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned CNT_W    = 10;
	localparam int unsigned PRE_W    = 7;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_COMPARE_A_VALUE   = 8'h04;
	localparam logic [7:0] OFF_PERIOD_COMPARE_VALUE   = 8'h08;
	localparam logic [7:0] OFF_COUNT  = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;

	// timer_control_one field positions
	localparam int unsigned CTRL_RUN   = 0;
	localparam int unsigned CTRL_MODE  = 1;
	localparam int unsigned CTRL_PINF  = 3;
	localparam int unsigned CTRL_CCLR  = 5;
	localparam int unsigned CTRL_CAPTS = 6;
	localparam int unsigned CTRL_OC    = 7;
	localparam int unsigned CTRL_POL   = 8;
	localparam int unsigned CTRL_PSEL  = 9;

	// Status flag positions, write one to clear
	localparam int unsigned STAT_A = 0;
	localparam int unsigned STAT_P = 1;

	localparam logic [31:0] RST_REG   = 32'h0000_0000;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_ERR  = 2'h2;

	// Pin function codes
	localparam logic [1:0] PIN_00     = 2'h0;
	localparam logic [1:0] PIN_01     = 2'h1;
	localparam logic [1:0] PIN_10     = 2'h2;
	localparam logic [1:0] PIN_SINGLE = 2'h3;

	typedef enum logic [1:0] {
		PTC_MODE_CMP = 2'b00,
		PTC_MODE_CAP = 2'b01,
		PTC_MODE_PWM = 2'b10,
		PTC_MODE_TMR = 2'b11
	} ptc_mode_e;
endpackage

/* File: core/ptc_timer.sv */
// Top module: 10-bit periodic timer with PWM, single pulse and capture modes behind AXI4-Lite
// Contract
// - PWM: period match clears counter; period 1..1023 counts that many, zero gives 1024
// - PWM: duty from compare A; compare A at or above period gives full duty
// - PWM counting and compares keep running with pin function 00 or 01
// - PWM: clear-select bit has no effect, period comparator always clears
// - Single pulse: run bit rising starts counter and gives pulse leading edge
// - Single pulse: active external clock pin edge sets run bit automatically
// - Pulse trailing edge whenever run bit clears, by software or compare A
// - Single pulse: compare A match clears run bit, setting pulse width
// - Single pulse: compare A match raises the timer interrupt request
// - Single pulse: counter resets to zero only on run bit rising edge
// - Single pulse: period value and clear-select bit ignored
// - Capture: counter starts when run bit rises
// - Capture: active edge copies counter into compare A and raises interrupt
// - Capture: counter free-runs until run bit falls
// - Capture: period match resets counter and raises interrupt
// - Capture: period value zero gives full 10-bit range
// - Capture: pin function picks edge; 11 disables capture, counter still runs
// - Capture: clear-select, initial level and polarity bits have no effect
// - Capture still happens on the pin even when it is driven as an output
// - PWM: polarity bit inverts the waveform on the output pin
// - PWM: pin function enables waveform or forces pin fixed low or high
module ptc_timer (
	input  wire logic                        clock_i,
	input  wire logic                        rstn_i,
	input  wire logic                        external_clock_pin_i,
	input  wire logic                        capture_input_pin_i,
	output logic                             timer_out_o,
	output logic                             timer_irq_o,
	input  wire logic [ptc_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ptc_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	import ptc_pkg::*;

	typedef struct packed {
		logic             run;
		ptc_mode_e        mode;
		logic [1:0]       pinf;
		logic             cclr;
		logic             capts;
		logic             oc;
		logic             pol;
		logic [2:0]       psel;
		logic [CNT_W-1:0] compare_a_value;
		logic [CNT_W-1:0] period_compare_value;
		logic [CNT_W-1:0] cnt;
		logic [PRE_W-1:0] presc;
		logic             run_prev;
		logic             ext_prev;
		logic             cap_prev;
		logic [1:0]       flags;
		logic             out;
		logic             irq;
		logic             aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic             w_have;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} ptc_state_s;

	ptc_state_s       s_q;
	ptc_state_s       s_d;
	logic [31:0]      wmask;
	logic [PRE_W-1:0] pre_mask;
	logic             tick;
	logic             running;
	logic             run_rise;
	logic             pmatch;
	logic             amatch;
	logic             is_pwm;
	logic             is_sp;
	logic             is_cap;
	logic             ext_rise;
	logic             src_now;
	logic             src_prev;
	logic             cap_hit;
	logic             full_duty;
	logic             wave;
	logic             wr_fire;

	// Byte enables widened to a bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mask
			assign wmask[gi*8 +: 8] = {8{s_q.w_strb[gi]}};
		end
	endgenerate

	// Prescaler divides the system clock by 2 to the power psel
	assign pre_mask = PRE_W'(7'h7F >> (3'd7 - s_q.psel));
	assign tick     = (s_q.presc & pre_mask) == pre_mask;
	assign running  = s_q.run & s_q.run_prev;
	assign run_rise = s_q.run & ~s_q.run_prev;
	// Match one below the period value; zero wraps to 1023, giving 1024 counts
	assign pmatch   = s_q.cnt == (s_q.period_compare_value - 10'h001);
	assign amatch   = s_q.cnt == s_q.compare_a_value;
	assign is_pwm   = (s_q.mode == PTC_MODE_PWM) && (s_q.pinf != PIN_SINGLE);
	assign is_sp    = (s_q.mode == PTC_MODE_PWM) && (s_q.pinf == PIN_SINGLE);
	assign is_cap   = s_q.mode == PTC_MODE_CAP;
	assign ext_rise = external_clock_pin_i & ~s_q.ext_prev;
	// The pin is sampled whatever its direction, so an output pin still captures
	assign src_now  = s_q.capts ? external_clock_pin_i : capture_input_pin_i;
	assign src_prev = s_q.capts ? s_q.ext_prev : s_q.cap_prev;
	assign wr_fire  = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
	assign full_duty = (s_q.period_compare_value != 10'h000) && (s_q.compare_a_value >= s_q.period_compare_value);
	assign wave      = full_duty | (s_q.cnt < s_q.compare_a_value);

	always_comb begin
		cap_hit = 1'b0;
		if (is_cap) begin
			case (s_q.pinf)
				PIN_00:  cap_hit = src_now & ~src_prev;
				PIN_01:  cap_hit = ~src_now & src_prev;
				PIN_10:  cap_hit = src_now ^ src_prev;
				default: cap_hit = 1'b0;
			endcase
		end
	end

	always_comb begin
		logic [31:0] ctrl_rd;
		logic [31:0] merged;
		ctrl_rd = RST_REG;
		merged  = RST_REG;
		s_d     = s_q;
		s_d.irq = 1'b0;
		s_d.presc    = s_q.presc + 7'h01;
		s_d.run_prev = s_q.run;
		s_d.ext_prev = external_clock_pin_i;
		s_d.cap_prev = capture_input_pin_i;

		ctrl_rd[CTRL_RUN]        = s_q.run;
		ctrl_rd[CTRL_MODE +: 2]  = s_q.mode;
		ctrl_rd[CTRL_PINF +: 2]  = s_q.pinf;
		ctrl_rd[CTRL_CCLR]       = s_q.cclr;
		ctrl_rd[CTRL_CAPTS]      = s_q.capts;
		ctrl_rd[CTRL_OC]         = s_q.oc;
		ctrl_rd[CTRL_POL]        = s_q.pol;
		ctrl_rd[CTRL_PSEL +: 3]  = s_q.psel;

		// Write channels are taken independently and held until both are present
		if (s_axi_awvalid && !s_q.aw_have) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_have) begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = RESP_OK;
			if (s_q.aw_addr == OFF_CTRL) begin
				merged    = (ctrl_rd & ~wmask) | (s_q.w_data & wmask);
				s_d.run   = merged[CTRL_RUN];
				s_d.mode  = ptc_mode_e'(merged[CTRL_MODE +: 2]);
				s_d.pinf  = merged[CTRL_PINF +: 2];
				s_d.cclr  = merged[CTRL_CCLR];
				s_d.capts = merged[CTRL_CAPTS];
				s_d.oc    = merged[CTRL_OC];
				s_d.pol   = merged[CTRL_POL];
				s_d.psel  = merged[CTRL_PSEL +: 3];
			end else if (s_q.aw_addr == OFF_COMPARE_A_VALUE) begin
				merged   = ({22'h0, s_q.compare_a_value} & ~wmask) | (s_q.w_data & wmask);
				s_d.compare_a_value = merged[CNT_W-1:0];
			end else if (s_q.aw_addr == OFF_PERIOD_COMPARE_VALUE) begin
				merged   = ({22'h0, s_q.period_compare_value} & ~wmask) | (s_q.w_data & wmask);
				s_d.period_compare_value = merged[CNT_W-1:0];
			end else if (s_q.aw_addr == OFF_STATUS) begin
				if (s_q.w_strb[0]) begin
					s_d.flags = s_q.flags & ~s_q.w_data[1:0];
				end
			end else if (s_q.aw_addr != OFF_COUNT) begin
				s_d.bresp = RESP_ERR;
			end
		end

		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RESP_OK;
			s_d.rdata  = RST_REG;
			if (s_axi_araddr == OFF_CTRL) begin
				s_d.rdata = ctrl_rd;
			end else if (s_axi_araddr == OFF_COMPARE_A_VALUE) begin
				s_d.rdata = {22'h0, s_q.compare_a_value};
			end else if (s_axi_araddr == OFF_PERIOD_COMPARE_VALUE) begin
				s_d.rdata = {22'h0, s_q.period_compare_value};
			end else if (s_axi_araddr == OFF_COUNT) begin
				s_d.rdata = {22'h0, s_q.cnt};
			end else if (s_axi_araddr == OFF_STATUS) begin
				s_d.rdata = {30'h0, s_q.flags};
			end else begin
				s_d.rresp = RESP_ERR;
			end
		end

		// Hardware events come after software so they win a same-cycle conflict
		// The clear-select bit is not read anywhere in these modes
		if (run_rise) begin
			s_d.cnt = 10'h000;
		end else if (running && tick) begin
			if (is_sp) begin
				if (amatch) begin
					s_d.run          = 1'b0;
					s_d.irq          = 1'b1;
					s_d.flags[STAT_A] = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt + 10'h001;
				end
			end else begin
				if (pmatch) begin
					s_d.cnt = 10'h000;
				end else begin
					s_d.cnt = s_q.cnt + 10'h001;
				end
				if (pmatch && (is_pwm || is_cap)) begin
					s_d.irq           = 1'b1;
					s_d.flags[STAT_P] = 1'b1;
				end
				if (amatch && is_pwm) begin
					s_d.irq           = 1'b1;
					s_d.flags[STAT_A] = 1'b1;
				end
			end
		end

		if (cap_hit) begin
			s_d.compare_a_value          = s_q.cnt;
			s_d.irq           = 1'b1;
			s_d.flags[STAT_A] = 1'b1;
		end
		if (is_sp && ext_rise && !s_q.run) begin
			s_d.run = 1'b1;
		end

		// Output pin level; capture and timer modes leave the pin low
		s_d.out = 1'b0;
		if (is_pwm) begin
			case (s_q.pinf)
				PIN_00:  s_d.out = 1'b0;
				PIN_01:  s_d.out = 1'b1;
				default: s_d.out = s_q.pol ^ (wave ? s_q.oc : ~s_q.oc);
			endcase
		end else if (is_sp) begin
			s_d.out = s_q.pol ^ (s_q.run ? s_q.oc : ~s_q.oc);
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign timer_out_o   = s_q.out;
	assign timer_irq_o   = s_q.irq;
	assign s_axi_awready = ~s_q.aw_have;
	assign s_axi_wready  = ~s_q.w_have;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = ~s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	sequence run_start_s;
		!s_q.run ##1 s_q.run;
	endsequence

	sequence sp_stop_s;
		is_sp && running && tick && amatch;
	endsequence

	a_period_clear: assert property ((is_pwm || is_cap) && running && tick && pmatch && !run_rise
		|=> s_q.cnt == 10'h000)
		else $error("period match did not clear counter");

	a_full_duty: assert property (is_pwm && s_q.pinf == PIN_10 && full_duty
		|=> timer_out_o == ($past(s_q.pol) ^ $past(s_q.oc)))
		else $error("full duty output not active");

	a_forced_low: assert property (is_pwm && s_q.pinf == PIN_00 |=> !timer_out_o)
		else $error("forced low pin not low");

	a_sp_stop_irq: assert property (sp_stop_s |=> !s_q.run && timer_irq_o)
		else $error("compare A did not end single pulse");

	a_sp_trailing: assert property (sp_stop_s ##1 is_sp |=> timer_out_o == (s_q.pol ^ ~s_q.oc))
		else $error("pulse trailing edge missing");

	a_ext_start: assert property (is_sp && ext_rise && !s_q.run |=> s_q.run)
		else $error("external edge did not set run bit");

	a_run_restart: assert property (run_start_s |=> s_q.cnt == 10'h000)
		else $error("counter not zeroed on restart");

	a_sp_hold: assert property (is_sp && !s_q.run && !run_rise |=> $stable(s_q.cnt))
		else $error("counter moved while pulse idle");

	a_capture_copy: assert property (cap_hit |=> s_q.compare_a_value == $past(s_q.cnt) && timer_irq_o)
		else $error("capture did not latch counter");

	a_cap_wrap_irq: assert property (is_cap && running && tick && pmatch
		|=> timer_irq_o ##0 s_q.cnt == 10'h000)
		else $error("capture wrap missing interrupt");

endmodule // ptc_timer
